// ===== logic/csr_pkg.sv
// Package for the core status and option register pair.
// Assumes one system clock and a synchronous active-high reset.
package csr_pkg;
    // Status register bit positions.
    localparam int STAT_CARRY = 0;
    localparam int STAT_DIGIT_CARRY = 1;
    localparam int STAT_ZERO = 2;
    localparam int STAT_POWERDOWN = 3;
    localparam int STAT_TIMEOUT = 4;
    localparam int STAT_PAGE = 5;
    localparam int STAT_CMP_WAKE = 6;
    localparam int STAT_PIN_WAKE = 7;
    // Option register bit positions.
    localparam int OPT_RATE_LSB = 0;
    localparam int OPT_ASSIGN = 3;
    localparam int OPT_EDGE = 4;
    localparam int OPT_SOURCE = 5;
    localparam int OPT_PULLUP_DIS = 6;
    localparam int OPT_WAKE_DIS = 7;
    // Reset values.
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [7:0] STATUS_POR = 8'h18;
    localparam logic [7:0] STATUS_FLAG_MASK = 8'h07;
    localparam logic [7:0] STATUS_TOPD_MASK = 8'h18;
    localparam logic [7:0] STATUS_UPPER_MASK = 8'hE0;
    // Program page bases.
    localparam logic [9:0] PAGE0_BASE = 10'h000;
    localparam logic [9:0] PAGE1_BASE = 10'h200;
    // Number of port pins covered by wake and pull-up gating.
    localparam int NUM_PINS = 6;
    // Index of the timer clock pin within the port.
    localparam int TIMER_PIN = 2;
    // Reset causes reported to the block.
    typedef enum logic [1:0] {
        CSR_RST_POWER_UP,
        CSR_RST_PIN_WAKE,
        CSR_RST_CMP_WAKE,
        CSR_RST_OTHER
    } csr_cause_e;
    // Arithmetic operation kinds driving the flags.
    typedef enum logic [2:0] {
        CSR_OP_NONE,
        CSR_OP_ADD,
        CSR_OP_SUB,
        CSR_OP_ROT_RIGHT,
        CSR_OP_ROT_LEFT,
        CSR_OP_LOGIC,
        CSR_OP_CLEAR
    } csr_op_e;
endpackage

// ===== logic/csr_alu_flags.sv
// Flag computation for arithmetic, logic, rotate and clear results.
// Assumes operands are stable in the cycle the operation is presented.
`timescale 1ns/1ns
module csr_alu_flags
    import csr_pkg::*;
(
    // Operation and operands.
    input wire csr_op_e op_i,
    input wire logic [7:0] file_i,
    input wire logic [7:0] work_i,
    input wire logic [7:0] logic_result_i,
    // Result and flags.
    output logic [7:0] result_o,
    output logic zero_o,
    output logic digit_carry_o,
    output logic carry_o,
    output logic zero_valid_o,
    output logic carry_valid_o,
    output logic digit_valid_o
);
    logic [8:0] sum_full;
    logic [4:0] sum_low;
    logic [8:0] diff_full;
    logic [4:0] diff_low;

    // Subtract is file minus work; carry out of a two's complement add means no borrow.
    assign sum_full = {1'b0, file_i} + {1'b0, work_i};
    assign sum_low = {1'b0, file_i[3:0]} + {1'b0, work_i[3:0]};
    assign diff_full = {1'b0, file_i} + {1'b0, ~work_i} + 9'h001;
    assign diff_low = {1'b0, file_i[3:0]} + {1'b0, ~work_i[3:0]} + 5'h01;

    // Select result and flags per operation.
    always_comb begin
        result_o = logic_result_i;
        digit_carry_o = 1'b0;
        carry_o = 1'b0;
        zero_valid_o = 1'b0;
        carry_valid_o = 1'b0;
        digit_valid_o = 1'b0;
        case (op_i)
            CSR_OP_ADD: begin
                result_o = sum_full[7:0];
                carry_o = sum_full[8];
                digit_carry_o = sum_low[4];
                zero_valid_o = 1'b1;
                carry_valid_o = 1'b1;
                digit_valid_o = 1'b1;
            end
            CSR_OP_SUB: begin
                result_o = diff_full[7:0];
                carry_o = diff_full[8];
                digit_carry_o = diff_low[4];
                zero_valid_o = 1'b1;
                carry_valid_o = 1'b1;
                digit_valid_o = 1'b1;
            end
            CSR_OP_ROT_RIGHT: begin
                result_o = {1'b0, file_i[7:1]};
                carry_o = file_i[0];
                carry_valid_o = 1'b1;
            end
            CSR_OP_ROT_LEFT: begin
                result_o = {file_i[6:0], 1'b0};
                carry_o = file_i[7];
                carry_valid_o = 1'b1;
            end
            CSR_OP_LOGIC: begin
                zero_valid_o = 1'b1;
            end
            CSR_OP_CLEAR: begin
                result_o = 8'h00;
                zero_valid_o = 1'b1;
            end
            default: begin
                result_o = logic_result_i;
            end
        endcase
    end

    // Zero flag follows the selected result.
    assign zero_o = (result_o == 8'h00);
endmodule

// ===== logic/csr_core_regs.sv
// Contract
// - Flag-updating instructions targeting status keep computed flags, not written data.
// - Instruction writes to time-out and power-down flags are ignored.
// - Clear-file on status clears upper three bits and sets zero.
// - Status bit 7 set on pin-change wake reset, cleared otherwise.
// - Status bit 6 set on comparator wake reset, cleared otherwise.
// - Status bit 5 selects program page; value as printed (code maps one to PAGE0_BASE and zero to PAGE1_BASE).
// - Time-out flag set by power-up, watchdog clear, sleep; cleared by time-out.
// - Power-down flag set by power-up or watchdog clear; cleared by sleep.
// - Zero flag set when result is zero, cleared otherwise.
// - Digit carry reflects carry, or no borrow, out of bit 3.
// - Carry reflects add carry, subtract no-borrow, or rotated-out bit.
// - Option register is write-only, loaded from working register by option instruction.
// - Every reset sets all option bits to one.
// - Output-direction pins lose wake-on-change and weak pull-up.
// - Option bit 7 low enables wake on pin change.
// - Option bit 6 low enables weak pull-ups.
// - Option bit 5 selects external pin or instruction clock for the timer.
// - External timer source overrides pin direction on the timer clock pin.
// - Option bit 4 selects falling edge when one, rising when zero.
// - Option bit 3 routes prescaler to watchdog when one, timer when zero.
// - Prescale code n gives timer 2^(n+1), watchdog 2^n (code seven shows the timer value as zero).
//
// Core status and option registers of a small 8-bit controller core.
// Assumes the core presents one instruction effect per cycle and that
// reset causes arrive with the reset pulse.
`timescale 1ns/1ns
module csr_core_regs
    import csr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire csr_cause_e reset_cause_i,
    // File write from the core.
    input wire logic status_wr_i,
    input wire logic [7:0] wr_data_i,
    input wire csr_op_e op_i,
    input wire logic [7:0] file_i,
    input wire logic [7:0] work_i,
    input wire logic [7:0] logic_result_i,
    input wire logic flags_update_i,
    // Special instructions and events.
    input wire logic option_load_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic sleep_instr_i,
    input wire logic watchdog_timeout_i,
    // Port direction and pin samples.
    input wire logic [NUM_PINS-1:0] pin_direction_i,
    input wire logic timer_ext_clock_pin_i,
    // Status and ALU result.
    output logic [7:0] core_status_o,
    output logic [7:0] alu_result_o,
    output logic [9:0] page_base_o,
    // Option-derived controls.
    output logic [NUM_PINS-1:0] pin_wake_enable_o,
    output logic [NUM_PINS-1:0] pin_pullup_enable_o,
    output logic [NUM_PINS-1:0] pin_direction_eff_o,
    output logic timer_tick_o,
    output logic prescaler_to_watchdog_o,
    output logic [7:0] timer_prescale_o,
    output logic [7:0] watchdog_prescale_o
);
    // Whole module state.
    typedef struct packed {
        logic [7:0] core_status;
        logic [7:0] timer_wake_options;
        logic pin_meta;
        logic pin_sync;
        logic pin_prev;
        logic tick;
    } csr_state_s;

    csr_state_s state_reg;
    csr_state_s state_next;
    logic [7:0] alu_result;
    logic zero_flag;
    logic digit_flag;
    logic carry_flag;
    logic zero_valid;
    logic carry_valid;
    logic digit_valid;
    logic [7:0] write_mask;
    logic [7:0] status_after_write;
    logic internal_tick;
    logic edge_seen;

    // Flag generation is shared with the instruction datapath.
    csr_alu_flags u_flags (
        .op_i(op_i),
        .file_i(file_i),
        .work_i(work_i),
        .logic_result_i(logic_result_i),
        .result_o(alu_result),
        .zero_o(zero_flag),
        .digit_carry_o(digit_flag),
        .carry_o(carry_flag),
        .zero_valid_o(zero_valid),
        .carry_valid_o(carry_valid),
        .digit_valid_o(digit_valid)
    );

    // Instruction cycle tick toggles every clock; a simple stand-in for the core's phase.
    assign internal_tick = state_reg.tick;

    // Edge on the synchronised timer pin, polarity chosen by the edge select.
    always_comb begin
        if (state_reg.timer_wake_options[OPT_EDGE]) begin
            edge_seen = state_reg.pin_prev & ~state_reg.pin_sync;
        end else begin
            edge_seen = ~state_reg.pin_prev & state_reg.pin_sync;
        end
    end

    // Bits that a write may touch: flags are protected when the instruction computes them.
    always_comb begin
        write_mask = ~STATUS_TOPD_MASK;
        if (flags_update_i) begin
            write_mask = write_mask & ~STATUS_FLAG_MASK;
        end
    end

    // Plain data write merged under the mask.
    assign status_after_write = (state_reg.core_status & ~write_mask)
        | (wr_data_i & write_mask);

    // Next-state logic for all registers.
    always_comb begin
        state_next = state_reg;
        state_next.tick = ~state_reg.tick;
        // The first flop only feeds the second.
        state_next.pin_meta = timer_ext_clock_pin_i;
        state_next.pin_sync = state_reg.pin_meta;
        state_next.pin_prev = state_reg.pin_sync;
        if (reset_i) begin
            state_next.timer_wake_options = OPTION_RESET;
            state_next.core_status = state_reg.core_status;
            state_next.core_status[STAT_PAGE] = 1'b0;
            state_next.core_status[STAT_PIN_WAKE] =
                (reset_cause_i == CSR_RST_PIN_WAKE);
            state_next.core_status[STAT_CMP_WAKE] =
                (reset_cause_i == CSR_RST_CMP_WAKE);
            if (reset_cause_i == CSR_RST_POWER_UP) begin
                state_next.core_status = STATUS_POR;
            end
            state_next.tick = 1'b0;
            state_next.pin_meta = 1'b0;
            state_next.pin_sync = 1'b0;
            state_next.pin_prev = 1'b0;
        end else begin
            // Computed flags land first; a write to status then overrides unmasked bits.
            if (zero_valid) begin
                state_next.core_status[STAT_ZERO] = zero_flag;
            end
            if (digit_valid) begin
                state_next.core_status[STAT_DIGIT_CARRY] = digit_flag;
            end
            if (carry_valid) begin
                state_next.core_status[STAT_CARRY] = carry_flag;
            end
            if (status_wr_i) begin
                if (op_i == CSR_OP_CLEAR) begin
                    // Upper bits cleared, zero set, the rest kept.
                    state_next.core_status =
                        (state_reg.core_status & ~STATUS_UPPER_MASK);
                    state_next.core_status[STAT_ZERO] = 1'b1;
                end else begin
                    state_next.core_status = (status_after_write & write_mask)
                        | (state_next.core_status & ~write_mask);
                end
            end
            // Hardware events own time-out and power-down; time-out has priority over clear.
            if (watchdog_clear_instr_i) begin
                state_next.core_status[STAT_TIMEOUT] = 1'b1;
                state_next.core_status[STAT_POWERDOWN] = 1'b1;
            end
            if (sleep_instr_i) begin
                state_next.core_status[STAT_TIMEOUT] = 1'b1;
                state_next.core_status[STAT_POWERDOWN] = 1'b0;
            end
            if (watchdog_timeout_i) begin
                state_next.core_status[STAT_TIMEOUT] = 1'b0;
            end
            if (option_load_i) begin
                state_next.timer_wake_options = work_i;
            end
        end
    end

    // State register.
    always_ff @(posedge clk_sys_i) begin
        state_reg <= state_next;
    end

    // Per-pin gating of wake and pull-up by direction and option bits.
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_pin
            if (g == TIMER_PIN) begin : g_timer
                // External source forces the pin to an input.
                assign pin_direction_eff_o[g] = pin_direction_i[g]
                    | state_reg.timer_wake_options[OPT_SOURCE];
            end else begin : g_plain
                assign pin_direction_eff_o[g] = pin_direction_i[g];
            end
            assign pin_wake_enable_o[g] = pin_direction_eff_o[g]
                & ~state_reg.timer_wake_options[OPT_WAKE_DIS];
            assign pin_pullup_enable_o[g] = pin_direction_eff_o[g]
                & ~state_reg.timer_wake_options[OPT_PULLUP_DIS];
        end
    endgenerate

    // Timer clock source: external edge or instruction clock.
    assign timer_tick_o = state_reg.timer_wake_options[OPT_SOURCE]
        ? edge_seen : internal_tick;

    // Prescaler routing and ratio, shown as one-hot divide values.
    assign prescaler_to_watchdog_o = state_reg.timer_wake_options[OPT_ASSIGN];
    // Code seven means 1:256, which falls out of eight bits and reads as zero.
    assign timer_prescale_o = 8'(9'h002
        << state_reg.timer_wake_options[OPT_RATE_LSB +: 3]);
    assign watchdog_prescale_o = 8'h01
        << state_reg.timer_wake_options[OPT_RATE_LSB +: 3];

    // Status reads and page base.
    assign core_status_o = state_reg.core_status;
    assign alu_result_o = alu_result;
    assign page_base_o = state_reg.core_status[STAT_PAGE] ? PAGE0_BASE : PAGE1_BASE;
endmodule

// ===== tb/csr_core_regs_checker.sv
// Concurrent checks for the status and option register pair.
// Assumes it is bound to csr_core_regs and sees only that module's ports.
`timescale 1ns/1ns
module csr_core_regs_checker
    import csr_pkg::*;
(
    // Clock, reset and core inputs.
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire csr_cause_e reset_cause_i,
    input wire logic status_wr_i,
    input wire csr_op_e op_i,
    input wire logic [7:0] file_i,
    input wire logic [7:0] work_i,
    input wire logic flags_update_i,
    input wire logic option_load_i,
    input wire logic watchdog_clear_instr_i,
    input wire logic sleep_instr_i,
    input wire logic watchdog_timeout_i,
    // Outputs under watch.
    input wire logic [7:0] core_status_o,
    input wire logic [9:0] page_base_o,
    input wire logic [NUM_PINS-1:0] pin_wake_enable_o,
    input wire logic [NUM_PINS-1:0] pin_pullup_enable_o,
    input wire logic [NUM_PINS-1:0] pin_direction_eff_o,
    input wire logic prescaler_to_watchdog_o,
    input wire logic [7:0] watchdog_prescale_o
);
    logic [8:0] sum;
    logic [2:0] arith_flags;
    logic arith;
    // Reference flags {zero, digit carry, carry}; subtract adds the complement so carry means no borrow.
    always_comb begin
        sum = {1'b0, file_i} + {1'b0, work_i};
        arith_flags = {sum[7:0] == 8'h00, 5'(file_i[3:0]) + 5'(work_i[3:0]) > 5'h0F, sum[8]};
        if (op_i == CSR_OP_SUB) begin
            sum = {1'b0, file_i} + {1'b0, ~work_i} + 9'h001;
            arith_flags = {sum[7:0] == 8'h00, file_i[3:0] >= work_i[3:0], sum[8]};
        end
        arith = flags_update_i && (op_i == CSR_OP_ADD || op_i == CSR_OP_SUB);
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence load_seq;
        option_load_i;
    endsequence

    AST_OPTION_LOAD: assert property (load_seq |=> watchdog_prescale_o ==
        (8'h01 << $past(work_i[2:0])) && prescaler_to_watchdog_o == $past(work_i[3]))
        else $error("option load not reflected in prescaler controls");
    AST_OPTION_RESET: assert property ($fell(reset_i) |-> watchdog_prescale_o == 8'h80
        && prescaler_to_watchdog_o && pin_pullup_enable_o == '0 && pin_wake_enable_o == '0)
        else $error("option register not all ones after reset");
    AST_WAKE_GATE: assert property (load_seq |=> pin_wake_enable_o ==
        ($past(work_i[7]) ? '0 : pin_direction_eff_o)) else $error("wake enable gating wrong");
    AST_PULLUP_GATE: assert property (load_seq |=> pin_pullup_enable_o ==
        ($past(work_i[6]) ? '0 : pin_direction_eff_o)) else $error("pull-up gating wrong");
    AST_TIMER_PIN: assert property (load_seq and work_i[5] |=> pin_direction_eff_o[TIMER_PIN])
        else $error("timer source did not override pin direction");
    AST_TOPD_LOCK: assert property (status_wr_i && !watchdog_clear_instr_i && !sleep_instr_i
        && !watchdog_timeout_i |=> $stable(core_status_o[4:3])) else $error("time-out bits written");
    AST_SLEEP_FLAGS: assert property (sleep_instr_i && !watchdog_timeout_i
        |=> core_status_o[4:3] == 2'b10) else $error("sleep did not set time-out and clear power-down");
    AST_TIMEOUT_CLR: assert property (watchdog_timeout_i |=> !core_status_o[STAT_TIMEOUT])
        else $error("watchdog time-out left time-out flag set");
    AST_CLEAR_FILE: assert property (status_wr_i && op_i == CSR_OP_CLEAR |=>
        core_status_o[7:5] == 3'b000 && core_status_o[2] && $stable(core_status_o[1:0]))
        else $error("clear of status gave wrong bits");
    AST_ARITH_FLAGS: assert property (arith |=> core_status_o[2:0] == $past(arith_flags))
        else $error("arithmetic flags wrong");
    AST_WAKE_CAUSE: assert property ($fell(reset_i) |-> core_status_o[7:5] ==
        {$past(reset_cause_i) == CSR_RST_PIN_WAKE, $past(reset_cause_i) == CSR_RST_CMP_WAKE, 1'b0})
        else $error("wake flags or page bit wrong after reset");
    AST_PAGE_BASE: assert property (page_base_o ==
        (core_status_o[STAT_PAGE] ? PAGE0_BASE : PAGE1_BASE)) else $error("page base wrong");
endmodule

bind csr_core_regs csr_core_regs_checker u_chk (.*);

// ===== tb/tb.sv
// Self-checking bench for the status and option register pair.
// Assumes csr_pkg, csr_core_regs and its checker are compiled first.
`timescale 1ns/1ns
module tb
    import csr_pkg::*;
;
    logic clk_sys_i, reset_i, status_wr_i, flags_update_i, option_load_i, timer_tick_o;
    logic watchdog_clear_instr_i, sleep_instr_i, watchdog_timeout_i, timer_ext_clock_pin_i;
    logic prescaler_to_watchdog_o;
    csr_cause_e reset_cause_i;
    csr_op_e op_i;
    logic [7:0] wr_data_i, file_i, work_i, logic_result_i, core_status_o, alu_result_o;
    logic [7:0] timer_prescale_o, watchdog_prescale_o;
    logic [9:0] page_base_o;
    logic [NUM_PINS-1:0] pin_direction_i, pin_wake_enable_o, pin_pullup_enable_o;
    logic [NUM_PINS-1:0] pin_direction_eff_o;
    int miscompares, cmp_count, ticks;
    csr_cause_e causes [3] = '{CSR_RST_PIN_WAKE, CSR_RST_CMP_WAKE, CSR_RST_OTHER};

    csr_core_regs uut (.*);

    // Free-running 100 MHz system clock.
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One instruction cycle; strobes drop by non-blocking assignment on the rising edge,
    // so each acts at that edge only; a back-to-back call holds them low until the next falling edge.
    task automatic cyc();
        @(posedge clk_sys_i);
        status_wr_i <= 1'b0;
        option_load_i <= 1'b0;
        flags_update_i <= 1'b0;
        watchdog_clear_instr_i <= 1'b0;
        sleep_instr_i <= 1'b0;
        watchdog_timeout_i <= 1'b0;
        op_i <= CSR_OP_NONE;
        @(negedge clk_sys_i);
    endtask

    task automatic do_reset(input csr_cause_e c);
        reset_i = 1'b1;
        reset_cause_i = c;
        repeat (5) @(negedge clk_sys_i);
        reset_i = 1'b0;
    endtask

    task automatic load_opt(input logic [7:0] v);
        work_i = v;
        option_load_i = 1'b1;
        cyc();
    endtask

    task automatic wr_stat(input logic [7:0] v, input csr_op_e op, input logic fu);
        wr_data_i = v;
        op_i = op;
        flags_update_i = fu;
        status_wr_i = 1'b1;
        cyc();
    endtask

    // The data written to 7:5 lands; the low flags come from the operation only.
    task automatic arith(input csr_op_e op, input logic [7:0] f, input logic [7:0] w,
            input logic [2:0] e, input logic [2:0] m);
        file_i = f;
        work_i = w;
        op_i = op;
        #1;
        if (op == CSR_OP_ADD || op == CSR_OP_SUB) begin
            chk("alu", {2'h0, (op == CSR_OP_ADD) ? 8'(f + w) : 8'(f - w)}, {2'h0, alu_result_o});
        end
        wr_stat(8'hE0, op, 1'b1);
        chk("flags", {7'h0, e & m}, {7'h0, core_status_o[2:0] & m});
        chk("upper", 10'h007, {7'h0, core_status_o[7:5]});
    endtask

    // Drives the timer pin to a level and counts ticks over six cycles.
    task automatic count_ticks(input logic lvl, input int exp);
        timer_ext_clock_pin_i = lvl;
        ticks = 0;
        repeat (6) begin
            cyc();
            if (timer_tick_o === 1'b1) ticks++;
        end
        chk("ticks", 10'(exp), 10'(ticks));
    endtask

    // Hang guard, far beyond the roughly 70 cycles the sequence needs.
    initial begin
        #200000;
        miscompares++;
        results();
    end

    initial begin
        {status_wr_i, flags_update_i, option_load_i, watchdog_clear_instr_i} = 4'h0;
        {sleep_instr_i, watchdog_timeout_i, timer_ext_clock_pin_i} = 3'h0;
        {wr_data_i, file_i, work_i, logic_result_i} = 32'h0;
        op_i = CSR_OP_NONE;
        pin_direction_i = 6'h2A;
        do_reset(CSR_RST_POWER_UP);
        chk("status", 10'h018, core_status_o);
        chk("wd_rate", 10'h080, watchdog_prescale_o);
        chk("pullup", 10'h000, pin_pullup_enable_o);
        load_opt(8'h00);
        chk("wake", 10'h02A, pin_wake_enable_o);
        chk("pullup", 10'h02A, pin_pullup_enable_o);
        chk("assign", 10'h000, prescaler_to_watchdog_o);
        for (int n = 0; n < 8; n++) begin
            load_opt(8'h38 | 8'(n));
            chk("tmr_rate", 10'(8'(9'h002 << n)), timer_prescale_o);
            chk("wd_rate", 10'(8'h01 << n), watchdog_prescale_o);
            chk("dir_eff", 10'h02E, pin_direction_eff_o);
            chk("assign", 10'h001, prescaler_to_watchdog_o);
        end
        count_ticks(1'b1, 0);
        count_ticks(1'b0, 1);
        load_opt(8'h20);
        count_ticks(1'b1, 1);
        wr_stat(8'hFF, CSR_OP_NONE, 1'b0);
        chk("page", 10'h000, page_base_o);
        wr_stat(8'h00, CSR_OP_NONE, 1'b0);
        chk("status", 10'h018, core_status_o);
        chk("page", 10'h200, page_base_o);
        sleep_instr_i = 1'b1;
        cyc();
        chk("status", 10'h010, core_status_o);
        wr_stat(8'h18, CSR_OP_NONE, 1'b0);
        chk("status", 10'h010, core_status_o);
        watchdog_clear_instr_i = 1'b1;
        cyc();
        chk("status", 10'h018, core_status_o);
        watchdog_timeout_i = 1'b1;
        sleep_instr_i = 1'b1;
        cyc();
        chk("status", 10'h000, core_status_o);
        watchdog_clear_instr_i = 1'b1;
        cyc();
        chk("status", 10'h018, core_status_o);
        wr_stat(8'hE3, CSR_OP_NONE, 1'b0);
        chk("status", 10'h0FB, core_status_o);
        wr_stat(8'h00, CSR_OP_CLEAR, 1'b1);
        chk("status", 10'h01F, core_status_o);
        arith(CSR_OP_ADD, 8'h0F, 8'h01, 3'b010, 3'b111);
        arith(CSR_OP_ADD, 8'hFF, 8'h01, 3'b111, 3'b111);
        arith(CSR_OP_ADD, 8'h12, 8'h34, 3'b000, 3'b111);
        arith(CSR_OP_SUB, 8'h05, 8'h05, 3'b111, 3'b111);
        arith(CSR_OP_SUB, 8'h03, 8'h05, 3'b000, 3'b111);
        arith(CSR_OP_SUB, 8'h10, 8'h01, 3'b001, 3'b111);
        arith(CSR_OP_ROT_RIGHT, 8'h01, 8'h00, 3'b001, 3'b001);
        arith(CSR_OP_ROT_LEFT, 8'h7F, 8'h00, 3'b000, 3'b001);
        arith(CSR_OP_ROT_LEFT, 8'h80, 8'h00, 3'b001, 3'b001);
        arith(CSR_OP_LOGIC, 8'h00, 8'h00, 3'b100, 3'b100);
        logic_result_i = 8'h5A;
        arith(CSR_OP_LOGIC, 8'h00, 8'h00, 3'b000, 3'b100);
        foreach (causes[i]) begin
            wr_stat(8'hE0, CSR_OP_NONE, 1'b0);
            do_reset(causes[i]);
            chk("wake", {8'h0, causes[i] == CSR_RST_PIN_WAKE, causes[i] == CSR_RST_CMP_WAKE},
                {8'h0, core_status_o[7:6]});
            chk("topd", 10'h003, {8'h0, core_status_o[4:3]});
            chk("wd_rate", 10'h080, watchdog_prescale_o);
        end
        results();
    end
endmodule
